// file: core/nfecc_ctrl.sv
// NAND flash ECC control register with self-clearing start bits.
// Assumes ECC result registers live elsewhere and pulse a read indication
// on the same clock when software reads them.
//
// Our own choices: register access over AHB-Lite and the register offsets.
module nfecc_ctrl
    import nfecc_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    input  wire logic                errloc_result_rd,
    input  wire logic                quad_parity_rd,
    input  wire logic [3:0]          single_result_rd,
    output logic [3:0]               nand_mode,
    output logic [3:0]               single_ecc_go,
    output logic                     quad_ecc_accum_go,
    output logic [1:0]               quad_ecc_chip_sel,
    output logic [3:0]               quad_ecc_route,
    output logic                     quad_ecc_errloc_calc_go
);

    // ==========================================================
    // Bus front end
    logic                 wr_stb;
    logic                 rd_stb;
    logic [NFECC_AW-1:0]  acc_addr;
    logic                 hit;

    nfecc_ahb_slave u_slave (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .wr_stb    (wr_stb),
        .rd_stb    (rd_stb),
        .acc_addr  (acc_addr)
    );

    assign hit = (acc_addr == NFECC_CTRL_OFS);

    // ==========================================================
    // Control state
    logic [3:0]  next_nand_mode;
    logic [3:0]  next_single_ecc_go;
    logic        next_quad_go;
    logic [1:0]  next_quad_sel;
    logic        next_calc_go;
    logic        wr_hit;

    assign wr_hit = wr_stb && hit;

    always_comb begin
        next_nand_mode     = nand_mode;
        next_quad_sel      = quad_ecc_chip_sel;
        next_quad_go       = quad_ecc_accum_go;
        next_calc_go       = quad_ecc_errloc_calc_go;
        next_single_ecc_go = single_ecc_go;
        // Clears by result reads come first so a same-cycle write of 1 wins
        if (errloc_result_rd) begin
            next_calc_go = 1'b0;
        end
        if (quad_parity_rd) begin
            next_quad_go = 1'b0;
        end
        next_single_ecc_go = next_single_ecc_go & ~single_result_rd;
        if (wr_hit) begin
            // Only defined fields are stored; reserved bits are dropped
            next_nand_mode = hwdata[NFECC_NAND_LSB +: NFECC_NCS];
            next_quad_sel  = hwdata[NFECC_QSEL_LSB +: 2];
            // Writing 0 to a start bit starts nothing and does not abort
            next_single_ecc_go = next_single_ecc_go
                               | hwdata[NFECC_SGO_LSB +: NFECC_NCS];
            if (hwdata[NFECC_QGO_BIT]) begin
                next_quad_go = 1'b1;
            end
            if (hwdata[NFECC_CALC_BIT]) begin
                next_calc_go = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nand_mode               <= NFECC_NAND_RST;
            quad_ecc_chip_sel       <= NFECC_QSEL_RST;
            quad_ecc_accum_go       <= NFECC_GO_RST;
            quad_ecc_errloc_calc_go <= NFECC_GO_RST;
            single_ecc_go           <= NFECC_SGO_RST;
        end else begin
            nand_mode               <= next_nand_mode;
            quad_ecc_chip_sel       <= next_quad_sel;
            quad_ecc_accum_go       <= next_quad_go;
            quad_ecc_errloc_calc_go <= next_calc_go;
            single_ecc_go           <= next_single_ecc_go;
        end
    end

    // ==========================================================
    // Four-bit ECC routing: one-hot start per chip select 0..3
    // Decode stays combinational so the route moves with the registered bits
    genvar gi;
    generate
        for (gi = 0; gi < NFECC_NCS; gi++) begin : g_route
            assign quad_ecc_route[gi] = quad_ecc_accum_go
                                      && (quad_ecc_chip_sel == 2'(gi));
        end
    endgenerate

    // ==========================================================
    // Read data: registered in the data phase word
    logic [31:0] rd_word;
    logic [31:0] next_hrdata;

    always_comb begin
        rd_word = NFECC_ZERO32;
        rd_word[NFECC_NAND_LSB +: NFECC_NCS] = nand_mode;
        rd_word[NFECC_QSEL_LSB +: 2]         = quad_ecc_chip_sel;
        rd_word[NFECC_SGO_LSB +: NFECC_NCS]  = single_ecc_go;
        rd_word[NFECC_QGO_BIT]               = quad_ecc_accum_go;
        rd_word[NFECC_CALC_BIT]              = quad_ecc_errloc_calc_go;
        next_hrdata = NFECC_ZERO32;
        if (hsel && hready && htrans[1] && !hwrite
            && haddr[NFECC_AW-1:0] == NFECC_CTRL_OFS) begin
            next_hrdata = rd_word;
        end
    end

    // Read value is sampled at the address phase so hrdata is a flop output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= NFECC_ZERO32;
        end else begin
            hrdata <= next_hrdata;
        end
    end

    // ==========================================================
    // Checks
    logic unused_ok;
    assign unused_ok = rd_stb | (hsize == NFECC_HSIZE_WORD);

    property p_calc_set;
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && hwdata[NFECC_CALC_BIT]) |=> quad_ecc_errloc_calc_go;
    endproperty
    a_calc_set: assert property (p_calc_set) else $error("calc go not set");

    property p_calc_clr;
        @(posedge hclk) disable iff (!hresetn)
        (errloc_result_rd && !(wr_hit && hwdata[NFECC_CALC_BIT])) |=> !quad_ecc_errloc_calc_go;
    endproperty
    a_calc_clr: assert property (p_calc_clr) else $error("calc go not cleared");

    property p_quad_set;
        @(posedge hclk) disable iff (!hresetn)
        (wr_hit && hwdata[NFECC_QGO_BIT]) |=> quad_ecc_accum_go
            && quad_ecc_route[$past(hwdata[NFECC_QSEL_LSB +: 2])];
    endproperty
    a_quad_set: assert property (p_quad_set) else $error("quad go not routed");

    property p_quad_clr;
        @(posedge hclk) disable iff (!hresetn)
        (quad_parity_rd && !(wr_hit && hwdata[NFECC_QGO_BIT])) |=> !quad_ecc_accum_go;
    endproperty
    a_quad_clr: assert property (p_quad_clr) else $error("quad go not cleared");

    property p_single_set;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit |=> ((single_ecc_go & $past(hwdata[NFECC_SGO_LSB +: NFECC_NCS]))
                    == $past(hwdata[NFECC_SGO_LSB +: NFECC_NCS]));
    endproperty
    a_single_set: assert property (p_single_set) else $error("single go lost");

    property p_single_clr;
        @(posedge hclk) disable iff (!hresetn)
        !wr_hit |=> ((single_ecc_go & $past(single_result_rd)) == 4'h0);
    endproperty
    a_single_clr: assert property (p_single_clr) else $error("single go kept");

    property p_nand;
        @(posedge hclk) disable iff (!hresetn)
        wr_hit |=> nand_mode == $past(hwdata[NFECC_NAND_LSB +: NFECC_NCS])
                   && quad_ecc_chip_sel == $past(hwdata[NFECC_QSEL_LSB +: 2]);
    endproperty
    a_nand: assert property (p_nand) else $error("mode bits wrong");

    property p_resv;
        @(posedge hclk) disable iff (!hresetn)
        hrdata[$bits(hrdata)-1:NFECC_CALC_BIT+1] == '0
            && hrdata[NFECC_SGO_LSB-1:NFECC_QSEL_LSB+2] == '0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits nonzero");

    // ==========================================================
    // Bus-level checks: address phase on the pins, data phase one cycle later
    logic addr_take;

    assign addr_take = hsel && hready
                     && (htrans == NFECC_HTRANS_NONSEQ || htrans == NFECC_HTRANS_SEQ);

    sequence s_ctrl_wr_addr;
        addr_take && hwrite && (haddr[NFECC_AW-1:0] == NFECC_CTRL_OFS);
    endsequence

    sequence s_ctrl_rd_addr;
        addr_take && !hwrite && (haddr[NFECC_AW-1:0] == NFECC_CTRL_OFS);
    endsequence

    sequence s_calc_wr;
        s_ctrl_wr_addr ##1 hwdata[NFECC_CALC_BIT];
    endsequence

    sequence s_quad_wr;
        s_ctrl_wr_addr ##1 hwdata[NFECC_QGO_BIT];
    endsequence

    property p_bus_calc;
        @(posedge hclk) disable iff (!hresetn)
        s_calc_wr |=> quad_ecc_errloc_calc_go;
    endproperty
    a_bus_calc: assert property (p_bus_calc) else $error("calc not started by bus");

    property p_bus_quad;
        @(posedge hclk) disable iff (!hresetn)
        s_quad_wr |=> quad_ecc_accum_go;
    endproperty
    a_bus_quad: assert property (p_bus_quad) else $error("quad not started by bus");

    // Read data is captured from the register state at the address phase
    property p_bus_rd;
        @(posedge hclk) disable iff (!hresetn)
        s_ctrl_rd_addr |=> (hrdata == $past(rd_word));
    endproperty
    a_bus_rd: assert property (p_bus_rd) else $error("read data wrong");

    property p_rd_idle;
        @(posedge hclk) disable iff (!hresetn)
        !(rd_stb && hit) |-> (hrdata == NFECC_ZERO32);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read phase");

    // Route is a pure decode of the registered start bit and select
    property p_route_idle;
        @(posedge hclk) disable iff (!hresetn)
        !quad_ecc_accum_go |-> (quad_ecc_route == 4'h0);
    endproperty
    a_route_idle: assert property (p_route_idle) else $error("quad route without start");

    property p_route_sel;
        @(posedge hclk) disable iff (!hresetn)
        quad_ecc_accum_go |-> (quad_ecc_route == (4'h1 << quad_ecc_chip_sel));
    endproperty
    a_route_sel: assert property (p_route_sel) else $error("quad route wrong");

    // Mode and select change only by a write; start bits rise only by a write
    property p_mode_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_hit |=> $stable(nand_mode) && $stable(quad_ecc_chip_sel);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed without write");

    property p_go_hold;
        @(posedge hclk) disable iff (!hresetn)
        !wr_hit |=> !$rose(quad_ecc_accum_go) && !$rose(quad_ecc_errloc_calc_go)
            && ((single_ecc_go & ~$past(single_ecc_go)) == 4'h0);
    endproperty
    a_go_hold: assert property (p_go_hold) else $error("start bit rose without write");

    // No disable: checked from the second edge of reset, once the clear has taken
    property p_reset_zero;
        @(posedge hclk)
        (!hresetn && !$past(hresetn)) |-> (nand_mode == NFECC_NAND_RST)
            && (single_ecc_go == NFECC_SGO_RST) && (quad_ecc_chip_sel == NFECC_QSEL_RST)
            && (quad_ecc_accum_go == NFECC_GO_RST) && (quad_ecc_errloc_calc_go == NFECC_GO_RST)
            && (hrdata == NFECC_ZERO32);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("reset did not clear");

endmodule

// file: shared/nfecc_pkg.sv
// NAND ECC control register package: offsets, field positions, reset values.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
package nfecc_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] NFECC_CTRL_OFS = 8'h00;
    localparam int NFECC_AW = 8;

    // ==========================================================
    // Field positions
    localparam int NFECC_NAND_LSB  = 0;
    localparam int NFECC_QSEL_LSB  = 4;
    localparam int NFECC_SGO_LSB   = 8;
    localparam int NFECC_QGO_BIT   = 12;
    localparam int NFECC_CALC_BIT  = 13;
    localparam int NFECC_NCS       = 4;

    // ==========================================================
    // Reset values
    localparam logic [3:0]  NFECC_NAND_RST = 4'h0;
    localparam logic [1:0]  NFECC_QSEL_RST = 2'h0;
    localparam logic [3:0]  NFECC_SGO_RST  = 4'h0;
    localparam logic        NFECC_GO_RST   = 1'b0;
    localparam logic [31:0] NFECC_ZERO32   = 32'h0000_0000;

    // AHB encodings
    localparam logic [1:0] NFECC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] NFECC_HTRANS_SEQ    = 2'h3;
    localparam logic [2:0] NFECC_HSIZE_WORD    = 3'h2;

    typedef enum logic [0:0] {
        NFECC_IDLE = 1'b0,
        NFECC_DATA = 1'b1
    } nfecc_phase_t;

endpackage

// file: core/nfecc_ahb_slave.sv
// AHB-Lite slave front end: captures the address phase, issues one-cycle
// write and read strobes in the data phase. Zero wait states.
// Assumes a single master and single word transfers.
module nfecc_ahb_slave
    import nfecc_pkg::*;
(
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic                     wr_stb,
    output logic                     rd_stb,
    output logic [NFECC_AW-1:0]      acc_addr
);

    nfecc_phase_t          phase;
    nfecc_phase_t          next_phase;
    logic                  is_wr;
    logic                  next_is_wr;
    logic [NFECC_AW-1:0]   next_acc_addr;
    logic                  take;

    assign take = hsel && hready && (htrans == NFECC_HTRANS_NONSEQ || htrans == NFECC_HTRANS_SEQ);

    always_comb begin
        next_phase    = take ? NFECC_DATA : NFECC_IDLE;
        next_is_wr    = take ? hwrite : is_wr;
        next_acc_addr = take ? haddr[NFECC_AW-1:0] : acc_addr;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase    <= NFECC_IDLE;
            is_wr    <= 1'b0;
            acc_addr <= '0;
        end else begin
            phase    <= next_phase;
            is_wr    <= next_is_wr;
            acc_addr <= next_acc_addr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_stb    = (phase == NFECC_DATA) && is_wr;
    assign rd_stb    = (phase == NFECC_DATA) && !is_wr;

endmodule

// file: verification/nfecc_tb.sv
// Self-checking bench for the NAND ECC control register.
// Assumes the zero-wait AHB-Lite slave of nfecc_ctrl and a 25 MHz clock.
module tb
    import nfecc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        errloc_result_rd;
    logic        quad_parity_rd;
    logic [3:0]  single_result_rd;
    logic [3:0]  nand_mode;
    logic [3:0]  single_ecc_go;
    logic        quad_ecc_accum_go;
    logic [1:0]  quad_ecc_chip_sel;
    logic [3:0]  quad_ecc_route;
    logic        quad_ecc_errloc_calc_go;
    logic [31:0] exp_reg;
    logic [31:0] rd;
    int          miscompares;
    int          checks;

    assign hready = hreadyout;

    nfecc_ctrl dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .errloc_result_rd(errloc_result_rd),
        .quad_parity_rd(quad_parity_rd), .single_result_rd(single_result_rd),
        .nand_mode(nand_mode), .single_ecc_go(single_ecc_go),
        .quad_ecc_accum_go(quad_ecc_accum_go), .quad_ecc_chip_sel(quad_ecc_chip_sel),
        .quad_ecc_route(quad_ecc_route), .quad_ecc_errloc_calc_go(quad_ecc_errloc_calc_go)
    );

    always #20 hclk = ~hclk;

    // ==========================================================
    // Reporting
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // Bus cycles: enter and leave just after a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("Error at %0t: bus wait ran out", $time);
            final_report();
        end
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= NFECC_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= NFECC_HSIZE_WORD;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        if (wr === 1'b1 && a === 32'(NFECC_CTRL_OFS)) begin
            // Start bits are set by 1 and kept by 0; mode and select are plain
            exp_reg = ((exp_reg | wd) & 32'h0000_3F00) | (wd & 32'h0000_003F);
        end
    endtask

    // Compares register readback and every control output with the model
    task automatic chk_all();
        @(posedge hclk);
        chk({18'h0, quad_ecc_errloc_calc_go, quad_ecc_accum_go, single_ecc_go, 2'h0,
             quad_ecc_chip_sel, nand_mode}, exp_reg);
        chk({28'h0, quad_ecc_route}, exp_reg[12] ? 32'h1 << exp_reg[5:4] : 32'h0);
        bus(1'b0, 32'h0000_0000, 32'h0);
        chk(rd, exp_reg);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk_all();
    endtask

    task automatic t_all_ones();
        bus(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
        chk_all();
        chk(exp_reg, 32'h0000_3F3F);
    endtask

    task automatic t_route();
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 32'h0000_0000, 32'h0000_1000 | (32'(s) << 4) | (32'h1 << s));
            chk_all();
        end
    endtask

    task automatic t_clears();
        for (int i = 0; i < 4; i++) begin
            single_result_rd <= 4'h1 << i;
            @(posedge hclk);
            single_result_rd <= 4'h0;
            exp_reg[8 + i] = 1'b0;
            chk_all();
        end
        quad_parity_rd <= 1'b1;
        @(posedge hclk);
        quad_parity_rd <= 1'b0;
        exp_reg[12] = 1'b0;
        chk_all();
        errloc_result_rd <= 1'b1;
        @(posedge hclk);
        errloc_result_rd <= 1'b0;
        exp_reg[13] = 1'b0;
        chk_all();
        bus(1'b1, 32'h0000_0000, 32'h0000_2000);
        chk_all();
    endtask

    // Result reads in the same data phase as the write that sets the bits
    task automatic t_set_wins();
        hsel   <= 1'b1;
        haddr  <= 32'(NFECC_CTRL_OFS);
        htrans <= NFECC_HTRANS_NONSEQ;
        hwrite <= 1'b1;
        wait_ready();
        hsel             <= 1'b0;
        htrans           <= 2'h0;
        hwdata           <= 32'h0000_3F00;
        errloc_result_rd <= 1'b1;
        quad_parity_rd   <= 1'b1;
        single_result_rd <= 4'hF;
        wait_ready();
        errloc_result_rd <= 1'b0;
        quad_parity_rd   <= 1'b0;
        single_result_rd <= 4'h0;
        exp_reg = 32'h0000_3F00;
        chk_all();
    endtask

    task automatic t_mid_reset();
        bus(1'b1, 32'h0000_0000, 32'h0000_1F2D);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        exp_reg = 32'h0;
        chk({18'h0, quad_ecc_errloc_calc_go, quad_ecc_accum_go, single_ecc_go, 2'h0,
             quad_ecc_chip_sel, nand_mode}, exp_reg);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_all();
    endtask

    task automatic t_unmapped();
        bus(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
        bus(1'b0, 32'h0000_0004, 32'h0);
        chk(rd, 32'h0000_0000);
        chk_all();
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = NFECC_HSIZE_WORD;
        hwdata = 32'h0;
        errloc_result_rd = 1'b0;
        quad_parity_rd = 1'b0;
        single_result_rd = 4'h0;
        exp_reg = 32'h0;
        miscompares = 0;
        checks = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_all_ones();
        t_route();
        t_clears();
        t_set_wins();
        t_mid_reset();
        t_unmapped();
        final_report();
    end
endmodule
